// ===== design/smdcs_sequencer.sv
/*
 * control and data path sequencer for an smd drive: tags, bus-out,
 * status, sector search, preamble and serial nrz data.
 * assumes the drive's cable signals arrive unsynchronised; the
 * servo clock is far slower than mclk_i and is sampled, not used as clock.
 */
// Behaviour
// - open cable detect first, activates interface
// - unit number strobed by unit tag, await selected
// - ten bus-out lines, eight bus-in, tag-defined
// - wait for unit ready before next operation
// - cylinder, head, then sector, then transfer
// - cylinder bits and head plus high cylinder
// - control tag bits carry gate and functions
// - on error, latch status for cause
// - nrz data timed by read, write, servo clocks
// - twelve byte preamble includes splice byte
// - splice byte uses preamble fill pattern
// - read gate 11.5 bits into preamble
// - header postamble of at least one byte before read gate only; write gate rises at the sector mark
`timescale 1ns/1ns
`include "smdcs_regs.svh"
module smdcs_sequencer (
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	input  wire logic              start_i,	// begin one operation
	input  wire logic              write_op_i,	// 1 write, 0 read
	input  wire logic [3:0]        unit_i,
	input  wire smdcs_pkg::smdcs_cyl_t cyl_i,
	input  wire logic [4:0]        head_i,
	input  wire logic [7:0]        sector_i,
	input  wire logic [15:0]       xfer_len_i,	// data bytes
	input  wire logic [3:0]        postamble_i,	// header postamble bytes
	input  wire logic              fault_clear_i,	// leave error state
	input  wire logic [7:0]        wr_byte_i,
	input  wire logic [7:0]        bus_in_i,
	input  wire logic              unit_selected_i,
	input  wire logic              servo_clk_i,
	input  wire logic              read_clk_i,
	input  wire logic              read_data_i,
	output logic                   open_cable_o,
	output logic [3:0]             unit_sel_o,
	output logic                   unit_tag_o,
	output logic                   cyl_tag_o,
	output logic                   head_tag_o,
	output logic                   ctrl_tag_o,
	output smdcs_pkg::smdcs_bus_t  bus_out_o,
	output logic                   write_clk_o,
	output logic                   write_data_o,
	output logic                   wr_take_o,	// pulse: wr_byte_i used
	output logic [7:0]             rd_byte_o,
	output logic                   rd_valid_o,	// pulse
	output logic                   busy_o,
	output logic                   done_o,	// pulse
	output logic                   error_o,
	output logic [7:0]             status_o
);
	import smdcs_pkg::*;
	////////////////////////////////////////////////////////////////////
	// synchronisers; first stage feeds only the second
	logic [11:0] sync1, sync2;	// cable inputs, two stages
	logic [3:0]  hist;	// previous synced clocks and marks
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1 <= 12'h000;
			sync2 <= 12'h000;
			hist  <= 4'h0;
		end else begin
			sync1 <= {read_data_i, read_clk_i, servo_clk_i,
				unit_selected_i, bus_in_i};
			sync2 <= sync1;
			hist  <= {sync2[10:9], sync2[`SMDCS_BI_SECTOR],
				sync2[`SMDCS_BI_INDEX]};
		end
	end
	// status view of bus-in and edges
	wire [7:0] bi       = sync2[7:0];
	wire       selected = sync2[8];
	wire       servo    = sync2[9];
	wire       rclk     = sync2[10];
	// data shares the clock's stage, so a clock edge and its bit align
	wire       rdat     = sync2[11];
	wire       index_r  = bi[`SMDCS_BI_INDEX] & ~hist[0];
	wire       sector_r = bi[`SMDCS_BI_SECTOR] & ~hist[1];
	wire       servo_e  = servo ^ hist[2];	// half bit tick
	wire       servo_f  = ~servo & hist[2];	// write data change
	wire       rclk_r   = rclk & ~hist[3];	// read sample
	// drive reports a fault or seek error
	wire       drv_bad  = bi[`SMDCS_BI_FAULT] | bi[`SMDCS_BI_SEEK_ERROR];
	////////////////////////////////////////////////////////////////////
	// state and counters
	smdcs_state_t state, next_state;
	logic [2:0]  step, next_step;	// tag strobe phase
	logic [7:0]  sec_cnt;	// sectors past index
	logic [15:0] cnt;	// half bits or bytes
	logic [2:0]  bitn;	// bit in serial byte
	logic [7:0]  shreg;	// serial shift register
	logic        in_pre;	// writing preamble bytes
	logic        found;
	// effective postamble never below one byte
	wire [3:0]  post_eff = (postamble_i < `SMDCS_MIN_POSTAMBLE) ?
		`SMDCS_MIN_POSTAMBLE : postamble_i;
	// read gate delay: postamble bytes then 11.5 bits of preamble
	wire [15:0] rg_delay = {8'h00, post_eff, 4'h0} +
		`SMDCS_RG_HALF_BITS;
	wire        tag_done = (step == `SMDCS_TAG_HOLD + 3'h1);
	wire        tag_high = (step != 3'h0) && !tag_done;
	wire        byte_end = servo_f && (bitn == `SMDCS_BIT_LAST);
	wire        xfer_end = in_pre ? 1'b0 : (cnt == xfer_len_i);
	////////////////////////////////////////////////////////////////////
	// next state: fixed order, a reported fault diverts in ready wait, seek wait, sector wait and transfer
	always_comb begin
		next_state = state;
		next_step  = 3'h0;
		unique case (state)
			ST_IDLE: if (start_i) next_state = ST_ACTIVATE;
			ST_ACTIVATE: begin
				next_step = step + 3'h1;
				if (step == `SMDCS_ACT_CYCLES) begin
					next_state = ST_SELECT;
					next_step  = 3'h0;
				end
			end
			ST_SELECT, ST_CYL, ST_HEAD, ST_CLEAR: begin
				next_step = step + 3'h1;
				if (tag_done) begin
					next_step = 3'h0;
					unique case (state)
						ST_SELECT: next_state = ST_SEL_WAIT;
						ST_CYL:    next_state = ST_HEAD;
						ST_HEAD:   next_state = ST_SEEK_WAIT;
						default:   next_state = ST_IDLE;
					endcase
				end
			end
			ST_SEL_WAIT: if (selected) next_state = ST_READY_WAIT;
			ST_READY_WAIT: begin
				if (drv_bad) next_state = ST_ERROR;
				else if (bi[`SMDCS_BI_UNIT_READY]) next_state = ST_CYL;
			end
			ST_SEEK_WAIT: begin
				if (drv_bad) next_state = ST_ERROR;
				else if (bi[`SMDCS_BI_ON_CYLINDER]) begin
					if (write_op_i && bi[`SMDCS_BI_WR_PROTECT])
						next_state = ST_ERROR;
					else next_state = ST_SECTOR_WAIT;
				end
			end
			ST_SECTOR_WAIT: begin
				if (drv_bad) next_state = ST_ERROR;
				else if (found)
					next_state = write_op_i ? ST_GATE_ON : ST_DELAY;
			end
			ST_DELAY: if (cnt == rg_delay) next_state = ST_GATE_ON;
			ST_GATE_ON: begin	// bus first, then tag
				next_step = step + 3'h1;
				if (step == 3'h1) next_state = ST_XFER;
			end
			ST_XFER: begin
				if (drv_bad) next_state = ST_ERROR;
				else if (xfer_end) next_state = ST_GATE_OFF;
			end
			ST_GATE_OFF: begin	// tag drops, then bus
				next_step = step + 3'h1;
				if (step == 3'h1) next_state = ST_IDLE;
			end
			ST_ERROR: if (fault_clear_i) next_state = ST_CLEAR;
		endcase
	end
	// bus-out word for the state, tags follow step
	smdcs_bus_t next_bus;
	always_comb begin
		next_bus = 10'h000;
		unique case (state)
			ST_CYL:  next_bus = cyl_i[9:0];
			ST_HEAD: next_bus = {3'h0, cyl_i[11:10], head_i};
			ST_GATE_ON, ST_XFER: begin
				next_bus[write_op_i ? `SMDCS_BO_WRITE_GATE :
					`SMDCS_BO_READ_GATE] = 1'b1;
			end
			ST_GATE_OFF: if (step == 3'h0) next_bus = bus_out_o;
			ST_CLEAR: next_bus[`SMDCS_BO_FAULT_CLEAR] = 1'b1;
			default: next_bus = 10'h000;
		endcase
	end
	////////////////////////////////////////////////////////////////////
	// control cable registers
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state        <= ST_IDLE;
			step         <= 3'h0;
			open_cable_o <= 1'b0;
			unit_sel_o   <= 4'h0;
			unit_tag_o   <= 1'b0;
			cyl_tag_o    <= 1'b0;
			head_tag_o   <= 1'b0;
			ctrl_tag_o   <= 1'b0;
			bus_out_o    <= 10'h000;
			error_o      <= 1'b0;
			status_o     <= 8'h00;
			busy_o       <= 1'b0;
			done_o       <= 1'b0;
		end else begin
			state      <= next_state;
			step       <= next_step;
			bus_out_o  <= next_bus;
			// activation stays on once raised
			if (state == ST_ACTIVATE) open_cable_o <= 1'b1;
			if (state == ST_SELECT && step == 3'h0)
				unit_sel_o <= unit_i;
			unit_tag_o <= (state == ST_SELECT) && tag_high;
			cyl_tag_o  <= (state == ST_CYL) && tag_high;
			head_tag_o <= (state == ST_HEAD) && tag_high;
			// gate tag held for the whole transfer
			ctrl_tag_o <= ((state == ST_CLEAR) && tag_high) ||
				((state == ST_GATE_ON) && step == 3'h1) ||
				(state == ST_XFER && next_state == ST_XFER);
			error_o    <= (next_state == ST_ERROR);
			// status frozen when the error is entered
			if (next_state == ST_ERROR && state != ST_ERROR)
				status_o <= bi;
			else if (state != ST_ERROR)
				status_o <= bi;
			busy_o <= (next_state != ST_IDLE) && (next_state != ST_ERROR);
			done_o <= (state == ST_GATE_OFF) && (next_state == ST_IDLE);
		end
	end
	////////////////////////////////////////////////////////////////////
	// sector search: index zeroes count, sector mark advances it
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sec_cnt <= 8'h00;
			found   <= 1'b0;
		end else begin
			found <= 1'b0;
			if (index_r) begin
				sec_cnt <= 8'h00;
				found   <= (sector_i == 8'h00) &&
					(state == ST_SECTOR_WAIT);
			end else if (sector_r) begin
				sec_cnt <= sec_cnt + 8'h01;
				found   <= (sector_i == sec_cnt + 8'h01) &&
					(state == ST_SECTOR_WAIT);
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// data path; write clock is servo retransmitted, data on its fall
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt          <= 16'h0000;
			bitn         <= 3'h0;
			shreg        <= 8'h00;
			in_pre       <= 1'b0;
			write_clk_o  <= 1'b0;
			write_data_o <= 1'b0;
			wr_take_o    <= 1'b0;
			rd_byte_o    <= 8'h00;
			rd_valid_o   <= 1'b0;
		end else begin
			write_clk_o <= servo;
			wr_take_o   <= 1'b0;
			rd_valid_o  <= 1'b0;
			if (state != ST_DELAY && state != ST_XFER) begin
				cnt    <= 16'h0000;
				bitn   <= 3'h0;
				in_pre <= 1'b1;
				// splice byte and preamble share the fill
				shreg  <= `SMDCS_FILL_PATTERN;
				write_data_o <= 1'b0;
			end else if (state == ST_DELAY) begin
				if (servo_e) cnt <= cnt + 16'h0001;
			end else if (write_op_i) begin
				if (servo_f) begin
					write_data_o <= shreg[7];
					shreg <= {shreg[6:0], 1'b0};
					bitn  <= bitn + 3'h1;
				end
				if (byte_end) begin
					cnt <= cnt + 16'h0001;
					// twelve preamble bytes, splice first
					if (in_pre && cnt == `SMDCS_PREAMBLE_BYTES -
						16'h0001) begin
						in_pre    <= 1'b0;
						cnt       <= 16'h0000;
						shreg     <= wr_byte_i;
						wr_take_o <= 1'b1;
					end else if (in_pre) begin
						shreg <= `SMDCS_FILL_PATTERN;
					end else begin
						shreg     <= wr_byte_i;
						wr_take_o <= (cnt + 16'h0001) != xfer_len_i;
					end
				end
			end else begin
				in_pre <= 1'b0;
				if (rclk_r) begin
					shreg <= {shreg[6:0], rdat};
					bitn  <= bitn + 3'h1;
					if (bitn == `SMDCS_BIT_LAST) begin
						rd_byte_o  <= {shreg[6:0], rdat};
						rd_valid_o <= 1'b1;
						cnt        <= cnt + 16'h0001;
					end
				end
			end
		end
	end
endmodule : smdcs_sequencer

// ===== design/smdcs_regs.svh
/*
 * named constants of the smd drive control sequencer: bus-out and bus-in
 * bit positions, format lengths and timing counts.
 * assumes inclusion by bare name, before the package and the module.
 */
`ifndef SMDCS_REGS_SVH
`define SMDCS_REGS_SVH
// control tag bus-out functions, bits zero to nine
`define SMDCS_BO_WRITE_GATE    4'd0
`define SMDCS_BO_READ_GATE     4'd1
`define SMDCS_BO_OFFSET_PLUS   4'd2
`define SMDCS_BO_OFFSET_MINUS  4'd3
`define SMDCS_BO_FAULT_CLEAR   4'd4
`define SMDCS_BO_ADDR_MARK_EN  4'd5
`define SMDCS_BO_RETURN_ZERO   4'd6
`define SMDCS_BO_STROBE_EARLY  4'd7
`define SMDCS_BO_STROBE_LATE   4'd8
`define SMDCS_BO_RELEASE       4'd9
// basic status bus-in bits
`define SMDCS_BI_UNIT_READY    3'd0
`define SMDCS_BI_ON_CYLINDER   3'd1
`define SMDCS_BI_SEEK_ERROR    3'd2
`define SMDCS_BI_FAULT         3'd3
`define SMDCS_BI_WR_PROTECT    3'd4
`define SMDCS_BI_ADDR_MARK_FND 3'd5
`define SMDCS_BI_INDEX         3'd6
`define SMDCS_BI_SECTOR        3'd7
// format: data preamble is phase lock field plus one splice byte
`define SMDCS_PLO_BYTES        16'h000b
`define SMDCS_PREAMBLE_BYTES   16'h000c
`define SMDCS_FILL_PATTERN     8'h00
`define SMDCS_MIN_POSTAMBLE    4'h1
// read gate lands 11.5 bit times into the preamble, in half bits
`define SMDCS_RG_HALF_BITS     16'h0017
`define SMDCS_HALF_PER_BYTE    16'h0010
// tag strobe: cycles high, cable activation settle
`define SMDCS_TAG_HOLD         3'h3
`define SMDCS_ACT_CYCLES       3'h7
`define SMDCS_BIT_LAST         3'h7
`endif

// ===== design/smdcs_pkg.sv
/*
 * types of the smd drive control sequencer.
 * assumes smdcs_regs.svh supplies the numeric constants.
 */
package smdcs_pkg;
	typedef logic [11:0] smdcs_cyl_t;	// cylinder address
	typedef logic [9:0]  smdcs_bus_t;	// bus-out word
	typedef enum logic [3:0] {
		ST_IDLE, ST_ACTIVATE, ST_SELECT, ST_SEL_WAIT, ST_READY_WAIT,
		ST_CYL, ST_HEAD, ST_SEEK_WAIT, ST_SECTOR_WAIT, ST_DELAY,
		ST_GATE_ON, ST_XFER, ST_GATE_OFF, ST_ERROR, ST_CLEAR
	} smdcs_state_t;
endpackage : smdcs_pkg

// ===== testbench/smdcs_sequencer_chk.sv
/* assertions on the sequencer's cable ports.
   assumes it is bound onto every smdcs_sequencer instance. */
`timescale 1ns/1ns
module smdcs_sequencer_chk (
	input wire logic                  mclk_i,
	input wire logic                  reset_n_i,
	input wire logic [3:0]            unit_i,
	input wire smdcs_pkg::smdcs_cyl_t cyl_i,
	input wire logic [4:0]            head_i,
	input wire logic                  open_cable_o,
	input wire logic [3:0]            unit_sel_o,
	input wire logic                  unit_tag_o,
	input wire logic                  cyl_tag_o,
	input wire logic                  head_tag_o,
	input wire logic                  ctrl_tag_o,
	input wire smdcs_pkg::smdcs_bus_t bus_out_o,
	input wire logic                  error_o,
	input wire logic                  done_o,
	input wire logic [7:0]            status_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// address tags: bus must not move under them
	wire adr_tag = unit_tag_o | cyl_tag_o | head_tag_o;
	wire any_tag = adr_tag | ctrl_tag_o;
	////////////////////////////////////////////////////////////////////
	a_open_first: assert property (any_tag |-> open_cable_o)
		else $error("tag before open cable");
	a_unit_strobe: assert property ($rose(unit_tag_o) |->
		unit_tag_o[*3] ##1 !unit_tag_o) else $error("unit tag width");
	a_unit_number: assert property (unit_tag_o |-> unit_sel_o == unit_i)
		else $error("unit number");
	a_cyl_bits: assert property (cyl_tag_o |-> bus_out_o == cyl_i[9:0])
		else $error("cylinder bits");
	a_head_bits: assert property (head_tag_o |->
		bus_out_o == {3'h0, cyl_i[11:10], head_i}) else $error("head bits");
	a_bus_stable: assert property (adr_tag || $past(adr_tag) |->
		$stable(bus_out_o)) else $error("bus moved under tag");
	a_cyl_then_head: assert property ($fell(cyl_tag_o) |->
		##[1:8] $rose(head_tag_o)) else $error("head tag late");
	a_gates_apart: assert property (ctrl_tag_o |->
		!(bus_out_o[0] && bus_out_o[1])) else $error("both gates");
	a_gate_ready: assert property (ctrl_tag_o && bus_out_o[1:0] != 2'h0
		|-> status_o[0]) else $error("gate while not ready");
	a_error_frozen: assert property (error_o && $past(error_o) |->
		$stable(status_o)) else $error("status moved in error");
	a_error_quiet: assert property (error_o |-> !adr_tag)
		else $error("address tag in error");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done not a pulse");
	c_head: cover property ($rose(head_tag_o));
	c_error: cover property ($rose(error_o));
	c_done: cover property (done_o);
endmodule : smdcs_sequencer_chk
bind smdcs_sequencer smdcs_sequencer_chk u_chk (.mclk_i, .reset_n_i,
	.unit_i, .cyl_i, .head_i, .open_cable_o, .unit_sel_o, .unit_tag_o,
	.cyl_tag_o, .head_tag_o, .ctrl_tag_o, .bus_out_o, .error_o, .done_o,
	.status_o);

// ===== testbench/smdcs_drive_model.sv
/* behavioural drive on the control and data cables.
   assumes tags held with a stable bus; servo clock free running. */
`timescale 1ns/1ns
module smdcs_drive_model #(
	parameter logic [3:0] MY_UNIT = 4'h5
) (
	input  wire logic       open_cable_i,
	input  wire logic [3:0] unit_sel_i,
	input  wire logic       unit_tag_i,
	input  wire logic       cyl_tag_i,
	input  wire logic       head_tag_i,
	input  wire logic       ctrl_tag_i,
	input  wire logic [9:0] bus_out_i,
	input  wire logic       write_clk_i,
	input  wire logic       write_data_i,
	input  wire logic       wr_protect_i,
	output logic [7:0]      bus_in_o,
	output logic            unit_selected_o,
	output logic            servo_clk_o,
	output logic            read_clk_o,
	output logic            read_data_o
);
	logic       on_cyl = 1'b0;	// seek finished
	logic       fault  = 1'b0;	// write gate refused
	logic [8:0] pos    = 9'h0;	// 8 sectors of 64 servo clocks
	logic [8:0] wr_pipe = 9'h0;	// write circuit delay line
	wire        rec_bit = wr_pipe[8];	// bit landing on the media
	// data reaches the media 8 write clocks late
	always @(posedge write_clk_i) wr_pipe <= {wr_pipe[7:0], write_data_i};
	initial unit_selected_o = 1'b0;
	initial read_data_o = 1'b0;
	initial servo_clk_o = 1'b0;
	////////////////////////////////////////////////////////////////////
	// servo clock never stops, read clock follows it
	always #16 servo_clk_o = ~servo_clk_o;
	assign read_clk_o = servo_clk_o;
	// tags other than unit select count only once selected
	wire rg = ctrl_tag_i & bus_out_i[1] & unit_selected_o;
	wire wg = ctrl_tag_i & bus_out_i[0] & unit_selected_o;
	// ones while gated; an ungated line toggles so nothing is trusted
	always @(negedge servo_clk_o) begin
		pos <= pos + 9'h1;
		read_data_o <= rg ? 1'b1 : ~read_data_o;
	end
	// status, index at sector 0, sector mark each 64 clocks
	assign bus_in_o = {pos[5:0] < 6'h2, pos < 9'h2, 1'b0, wr_protect_i,
		fault, 1'b0, on_cyl, unit_selected_o};
	always @(negedge unit_tag_i)
		unit_selected_o <= open_cable_i && unit_sel_i == MY_UNIT;
	always @(negedge cyl_tag_i) if (unit_selected_o) begin
		on_cyl <= 1'b0;
		on_cyl <= #400 1'b1;
	end
	always @(posedge wg) if (!unit_selected_o || !on_cyl) fault <= 1'b1;
	always @(negedge ctrl_tag_i) if (unit_selected_o && bus_out_i[4])
		fault <= 1'b0;
endmodule : smdcs_drive_model

// ===== testbench/smdcs_sequencer_tb.sv
/* self-checking bench: read, write, protected write, read.
   assumes the drive model answers as unit 5. */
`timescale 1ns/1ns
module smdcs_sequencer_tb;
	logic mclk_i = 0, reset_n_i = 0, start_i = 0, write_op_i = 0;
	logic fault_clear_i = 0, wp = 0;
	wire rec_bit = u_smdcs_drive_model.rec_bit;	// bit the drive records
	logic [3:0] unit_i = 4'h5, postamble_i = 4'h1, unit_sel_o;
	logic [4:0] head_i = 5'h0;
	logic [7:0] sector_i = 8'h0, wr_byte_i = 8'hff, bus_in_i;
	logic [7:0] rd_byte_o, status_o;
	logic [15:0] xfer_len_i = 16'h0, n_bytes = 16'h0;
	smdcs_pkg::smdcs_cyl_t cyl_i = '0;
	smdcs_pkg::smdcs_bus_t bus_out_o;
	logic unit_selected_i, servo_clk_i, read_clk_i, read_data_i;
	logic open_cable_o, unit_tag_o, cyl_tag_o, head_tag_o, ctrl_tag_o;
	logic write_clk_o, write_data_o, wr_take_o, rd_valid_o;
	logic busy_o, done_o, error_o, err_d = 0;
	int n_fail = 0, total_checks = 0, seed = 32'h967a, wbits = 0;
	logic [16:0] exp_q[$];	// {error, byte count} per operation
	always #2 mclk_i = ~mclk_i;
	smdcs_sequencer u_smdcs_sequencer (.*);
	smdcs_drive_model u_smdcs_drive_model (.open_cable_i(open_cable_o),
		.unit_sel_i(unit_sel_o), .unit_tag_i(unit_tag_o),
		.cyl_tag_i(cyl_tag_o), .head_tag_i(head_tag_o),
		.ctrl_tag_i(ctrl_tag_o), .bus_out_i(bus_out_o),
		.write_clk_i(write_clk_o), .write_data_i(write_data_o),
		.wr_protect_i(wp), .bus_in_o(bus_in_i),
		.unit_selected_o(unit_selected_i), .servo_clk_o(servo_clk_i),
		.read_clk_o(read_clk_i), .read_data_o(read_data_i));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		if (n_fail == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	// bounded wait: 0 result, 1 error left, 2 idle again
	task automatic wait_for(input int which);
		for (int i = 0; i < 20000; i++) begin
			@(posedge mclk_i);
			#1;
			if (which == 0 && (done_o === 1'b1 || error_o === 1'b1)) return;
			if (which == 1 && error_o === 1'b0) return;
			if (which == 2 && busy_o === 1'b0) return;
		end
		n_fail++;
		give_verdict();
	endtask : wait_for
	// one whole operation with random address and postamble
	task automatic run_op(input logic wr, input logic [15:0] len,
		input logic prot);
		@(posedge mclk_i);
		#1;
		write_op_i = wr;
		xfer_len_i = len;
		wp = prot;
		cyl_i = 12'($random(seed));
		head_i = 5'($random(seed));
		sector_i = 8'($unsigned($random(seed)) % 8);
		postamble_i = 4'($random(seed));	// zero means one byte
		exp_q.push_back({wr & prot, (wr & prot) ? 16'h0 : len});
		start_i = 1'b1;
		@(posedge mclk_i);
		#1;
		start_i = 1'b0;
		wait_for(0);
		if (wr & prot) begin
			fault_clear_i = 1'b1;
			wait_for(1);
			fault_clear_i = 1'b0;
		end
		wait_for(2);
	endtask : run_op
	////////////////////////////////////////////////////////////////////
	// result watcher: bytes counted, compared at done or error
	always @(negedge mclk_i) begin
		err_d <= error_o;
		if (rd_valid_o === 1'b1) begin
			n_bytes++;
			if (n_bytes > 1) check({9'h0, rd_byte_o}, 17'h000ff);
		end
		if (wr_take_o === 1'b1) n_bytes++;
		if (done_o === 1'b1 || (error_o === 1'b1 && err_d !== 1'b1)) begin
			check({error_o, n_bytes}, exp_q.pop_front());
			n_bytes = 0;
		end
	end
	// written stream: zero preamble of 12 bytes, then the ff data
	always @(posedge write_clk_o) begin
		#1;	// let the launching mclk edge settle
		if (ctrl_tag_o === 1'b1 && bus_out_o[0] === 1'b1) begin
			wbits++;
			if (wbits > 12 && wbits < 103) check({16'h0, rec_bit}, 17'h0);
			if (wbits > 109 && wbits < 114) check({16'h0, rec_bit}, 17'h1);
			if (wbits > 4 && wbits < 95) check({16'h0, write_data_o}, 17'h0);
			if (wbits > 101 && wbits < 106) check({16'h0, write_data_o}, 17'h1);
		end else wbits = 0;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		run_op(1'b0, 16'h4, 1'b0);
		run_op(1'b1, 16'h3, 1'b0);
		run_op(1'b1, 16'h2, 1'b1);
		run_op(1'b0, 16'h1, 1'b0);
		give_verdict();
	end
endmodule : smdcs_sequencer_tb
